//--- rtl/ipc_input_path_regs.sv
// configuration register bank for input path 2 with its mic clock and data capture
`timescale 1ns/1ps

// Function
// - bit 15 enables left highpass filter
// - independent right highpass enable at bit 15
// - bits 12:11 pick mic pin reference level
// - bit 10 analog or digital; mid-power code
// - oversample code sets digital mic clock rate
// - left gain 0x40 is 0 dB, 1 dB
// - right gain same encoding, resets to 0x40
// - bits 14:13 select left analog source pins
// - left bit 11 low power, analog only
// - path 1 right bit 11 low power
module ipc_input_path_regs (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    // avalon-mm slave
    input  wire logic [11:0]            address,
    input  wire logic                   read,
    input  wire logic                   write,
    input  wire logic [31:0]            writedata,
    input  wire logic [3:0]             byteenable,
    output logic                        waitrequest,
    output logic [31:0]                 readdata,
    output logic [1:0]                  response,
    // configuration towards the analog and filter paths
    output ipc_pkg::ipc_cfg_t           cfg,
    output ipc_pkg::ipc_mode_t          mode,
    // digital microphone pins
    output logic                        mic_clock_output,
    input  wire logic                   mic_data_input,
    // captured microphone bits
    output logic                        mic_left_bit,
    output logic                        mic_left_strobe,
    output logic                        mic_right_bit,
    output logic                        mic_right_strobe
);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // bus decode
    logic [9:0]  idx;            // register index from byte address
    logic        req;            // a request is present
    logic        commit;         // write takes effect at this edge
    logic        capture;        // read data are formed at this edge
    logic        hit_p1r;        // path 1 right source selected
    logic        hit_p2l_ctl;    // path 2 left control selected
    logic        hit_p2l_src;    // path 2 left source selected
    logic        hit_osr;        // oversample control selected
    logic        hit_p2r_ctl;    // path 2 right control selected
    logic        hit_status;     // status selected
    logic        mapped;         // any register selected
    logic        lo_lane;        // bits 7:0 written
    logic        hi_lane;        // bits 15:8 written
    logic        next_waitrequest;
    logic [31:0] next_readdata;
    logic [1:0]  next_response;

    assign idx      = address[11:2];
    assign req      = read | write;
    assign capture  = req & waitrequest;
    assign commit   = write & ~waitrequest;
    assign lo_lane  = byteenable[0];
    assign hi_lane  = byteenable[1];

    // address decode
    assign hit_p1r     = (idx == ipc_pkg::IDX_P1R_SOURCE);
    assign hit_p2l_ctl = (idx == ipc_pkg::IDX_P2L_CONTROL);
    assign hit_p2l_src = (idx == ipc_pkg::IDX_P2L_SOURCE);
    assign hit_osr     = (idx == ipc_pkg::IDX_P2_OVERSAMP);
    assign hit_p2r_ctl = (idx == ipc_pkg::IDX_P2R_CONTROL);
    assign hit_status  = (idx == ipc_pkg::IDX_STATUS);
    assign mapped      = hit_p1r | hit_p2l_ctl | hit_p2l_src | hit_osr
                       | hit_p2r_ctl | hit_status;

    // reserved-code detection for status
    logic ref_rsv;               // reference code reserved
    logic osr_rsv;               // oversample code reserved for current type
    logic lgain_rsv;             // left gain code reserved
    logic rgain_rsv;             // right gain code reserved
    logic osr_clock_code;        // code names a mic clock rate
    logic osr_analog_code;       // code names an analog power mode

    assign ref_rsv   = (cfg.mic_reference_select == ipc_pkg::REF_RESERVED);
    assign osr_clock_code  = (cfg.oversample_rate_select >= ipc_pkg::OSR_384K)
                           && (cfg.oversample_rate_select <= ipc_pkg::OSR_6144K);
    assign osr_analog_code = (cfg.oversample_rate_select == ipc_pkg::OSR_1536K)
                           || (cfg.oversample_rate_select == ipc_pkg::OSR_3072K);
    assign osr_rsv   = cfg.path_input_type ? ~osr_clock_code : ~osr_analog_code;
    assign lgain_rsv = (cfg.left_preamp_gain < ipc_pkg::GAIN_ZERO_DB)
                     || (cfg.left_preamp_gain >= ipc_pkg::GAIN_FIRST_RSV);
    assign rgain_rsv = (cfg.right_preamp_gain < ipc_pkg::GAIN_ZERO_DB)
                     || (cfg.right_preamp_gain >= ipc_pkg::GAIN_FIRST_RSV);

    // read words, unused bits read as zero
    logic [31:0] rd_p1r;
    logic [31:0] rd_p2l_ctl;
    logic [31:0] rd_p2l_src;
    logic [31:0] rd_osr;
    logic [31:0] rd_p2r_ctl;
    logic [31:0] rd_status;

    assign rd_p1r     = {16'h0000, 4'h0, cfg.path1_right_low_power_select, 11'h000};
    assign rd_p2l_ctl = {16'h0000, cfg.left_highpass_enable, 2'h0,
                         cfg.mic_reference_select, cfg.path_input_type, 2'h0,
                         cfg.left_preamp_gain, 1'b0};
    assign rd_p2l_src = {16'h0000, 1'b0, cfg.left_source_select, 1'b0,
                         cfg.left_low_power_select, 11'h000};
    assign rd_osr     = {16'h0000, 5'h00, cfg.oversample_rate_select, 8'h00};
    assign rd_p2r_ctl = {16'h0000, cfg.right_highpass_enable, 7'h00,
                         cfg.right_preamp_gain, 1'b0};
    assign rd_status  = {27'h0000000, rgain_rsv, lgain_rsv, osr_rsv, ref_rsv,
                         mic_clock_output};

    // read data select
    assign next_readdata = hit_p1r     ? rd_p1r     :
                           hit_p2l_ctl ? rd_p2l_ctl :
                           hit_p2l_src ? rd_p2l_src :
                           hit_osr     ? rd_osr     :
                           hit_p2r_ctl ? rd_p2r_ctl :
                           hit_status  ? rd_status  : 32'h00000000;
    assign next_response = mapped ? ipc_pkg::RESP_OKAY : ipc_pkg::RESP_SLVERR;
    // one wait cycle, then release for the completing edge
    assign next_waitrequest = ~capture;

    // bus handshake and answer registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            waitrequest <= 1'b1;
            readdata    <= 32'h00000000;
            response    <= ipc_pkg::RESP_OKAY;
        end else begin
            waitrequest <= next_waitrequest;
            if (capture) begin
                readdata <= read ? next_readdata : 32'h00000000;
                response <= next_response;
            end
        end
    end

    // write strobes per register and byte lane
    logic wr_p1r_hi;
    logic wr_ctl_l_hi;
    logic wr_ctl_l_lo;
    logic wr_src_hi;
    logic wr_osr_hi;
    logic wr_ctl_r_hi;
    logic wr_ctl_r_lo;

    assign wr_p1r_hi   = commit & hit_p1r & hi_lane;
    assign wr_ctl_l_hi = commit & hit_p2l_ctl & hi_lane;
    assign wr_ctl_l_lo = commit & hit_p2l_ctl & lo_lane;
    assign wr_src_hi   = commit & hit_p2l_src & hi_lane;
    assign wr_osr_hi   = commit & hit_osr & hi_lane;
    assign wr_ctl_r_hi = commit & hit_p2r_ctl & hi_lane;
    assign wr_ctl_r_lo = commit & hit_p2r_ctl & lo_lane;

    // path 2 left control fields
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg.left_highpass_enable <= ipc_pkg::RST_HPF;
            cfg.mic_reference_select <= ipc_pkg::RST_REF;
            cfg.path_input_type      <= ipc_pkg::RST_TYPE;
            cfg.left_preamp_gain     <= ipc_pkg::RST_GAIN;
        end else begin
            if (wr_ctl_l_hi) begin
                cfg.left_highpass_enable <= writedata[ipc_pkg::HPF_BIT];
                cfg.mic_reference_select <= writedata[ipc_pkg::REF_MSB:ipc_pkg::REF_LSB];
                cfg.path_input_type      <= writedata[ipc_pkg::TYPE_BIT];
            end
            if (wr_ctl_l_lo) begin
                cfg.left_preamp_gain <= writedata[ipc_pkg::GAIN_MSB:ipc_pkg::GAIN_LSB];
            end
        end
    end

    // path 2 right control fields
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg.right_highpass_enable <= ipc_pkg::RST_HPF;
            cfg.right_preamp_gain     <= ipc_pkg::RST_GAIN;
        end else begin
            if (wr_ctl_r_hi) begin
                cfg.right_highpass_enable <= writedata[ipc_pkg::HPF_BIT];
            end
            if (wr_ctl_r_lo) begin
                cfg.right_preamp_gain <= writedata[ipc_pkg::GAIN_MSB:ipc_pkg::GAIN_LSB];
            end
        end
    end

    // source, low-power and oversample fields
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg.left_source_select           <= ipc_pkg::RST_SRC;
            cfg.left_low_power_select        <= ipc_pkg::RST_LP;
            cfg.path1_right_low_power_select <= ipc_pkg::RST_LP;
            cfg.oversample_rate_select       <= ipc_pkg::RST_OSR;
        end else begin
            if (wr_src_hi) begin
                cfg.left_source_select    <= writedata[ipc_pkg::SRC_MSB:ipc_pkg::SRC_LSB];
                cfg.left_low_power_select <= writedata[ipc_pkg::LP_BIT];
            end
            if (wr_p1r_hi) begin
                cfg.path1_right_low_power_select <= writedata[ipc_pkg::LP_BIT];
            end
            if (wr_osr_hi) begin
                cfg.oversample_rate_select <= writedata[ipc_pkg::OSR_MSB:ipc_pkg::OSR_LSB];
            end
        end
    end

    // effective modes, left low power and gain only count for analog input
    ipc_pkg::ipc_mode_t next_mode;

    assign next_mode.digital_active   = cfg.path_input_type;
    assign next_mode.mid_power_active = ~cfg.path_input_type
                                      & (cfg.oversample_rate_select == ipc_pkg::OSR_1536K);
    assign next_mode.left_low_power   = ~cfg.path_input_type & cfg.left_low_power_select;
    assign next_mode.path1_right_low_power = cfg.path1_right_low_power_select;
    assign next_mode.left_gain_valid  = ~cfg.path_input_type & ~lgain_rsv;
    assign next_mode.right_gain_valid = ~cfg.path_input_type & ~rgain_rsv;
    assign next_mode.left_gain_db     = 5'(cfg.left_preamp_gain - ipc_pkg::GAIN_ZERO_DB);
    assign next_mode.right_gain_db    = 5'(cfg.right_preamp_gain - ipc_pkg::GAIN_ZERO_DB);

    // register the decoded modes so outputs come from flip-flops
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode <= '0;
        end else begin
            mode <= next_mode;
        end
    end

    // mic clock rate selection, reserved codes and analog input stop the clock
    logic [23:0] nco_inc;        // accumulator step for the selected rate
    logic        clk_run;        // mic clock enabled

    assign nco_inc = (cfg.oversample_rate_select == ipc_pkg::OSR_384K)  ? ipc_pkg::INC_384K  :
                     (cfg.oversample_rate_select == ipc_pkg::OSR_768K)  ? ipc_pkg::INC_768K  :
                     (cfg.oversample_rate_select == ipc_pkg::OSR_1536K) ? ipc_pkg::INC_1536K :
                     (cfg.oversample_rate_select == ipc_pkg::OSR_3072K) ? ipc_pkg::INC_3072K :
                                                                          ipc_pkg::INC_6144K;
    assign clk_run = cfg.path_input_type & osr_clock_code;

    logic rise_pulse;            // mic clock just rose
    logic fall_pulse;            // mic clock just fell

    ipc_mic_clock_gen #(
        .ACC_W      (ipc_pkg::NCO_W)
    ) u_mic_clock (
        .clk        (clk),
        .rst_n      (rst_n),
        .run        (clk_run),
        .increment  (nco_inc),
        .mic_clk    (mic_clock_output),
        .rise_pulse (rise_pulse),
        .fall_pulse (fall_pulse)
    );

    // capture left data after the rising edge, right data after the falling edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mic_left_bit     <= 1'b0;
            mic_left_strobe  <= 1'b0;
            mic_right_bit    <= 1'b0;
            mic_right_strobe <= 1'b0;
        end else begin
            mic_left_strobe  <= rise_pulse;
            mic_right_strobe <= fall_pulse;
            if (rise_pulse) begin
                mic_left_bit <= mic_data_input;
            end
            if (fall_pulse) begin
                mic_right_bit <= mic_data_input;
            end
        end
    end

    // handshake: one wait cycle then the completing cycle
    sequence s_req_start;
        req && waitrequest;
    endsequence
    sequence s_done;
        !waitrequest ##1 waitrequest;
    endsequence

    a_bus_one_wait: assert property (s_req_start |=> s_done)
        else $error("waitrequest did not release after one cycle");

    sequence s_wr_ctl_l;
        wr_ctl_l_hi;
    endsequence

    a_left_hpf_wr: assert property (s_wr_ctl_l |=>
        cfg.left_highpass_enable == $past(writedata[15]) ##1
        mode.digital_active == $past(cfg.path_input_type))
        else $error("left highpass enable or input type not taken from write");

    a_right_hpf_wr: assert property (wr_ctl_r_hi && !wr_ctl_l_hi |=>
        cfg.right_highpass_enable == $past(writedata[15])
        && $stable(cfg.left_highpass_enable))
        else $error("right highpass enable not independent");

    a_ref_sel_rd: assert property (capture && read && hit_p2l_ctl |=>
        readdata[12:11] == cfg.mic_reference_select && response == 2'h0)
        else $error("reference select readback wrong");

    a_mid_power: assert property (!cfg.path_input_type
        && cfg.oversample_rate_select == 3'h4 |=> mode.mid_power_active)
        else $error("mid power mode not entered for analog code 100");

    a_clock_rate_run: assert property (((clk_run
        && cfg.oversample_rate_select == 3'h5) [*3]) |-> ##[1:4] $changed(mic_clock_output))
        else $error("mic clock not toggling at the default rate");

    a_clock_stopped: assert property (!clk_run [*2] |-> !mic_clock_output)
        else $error("mic clock running while stopped");

    a_left_gain_db: assert property (!cfg.path_input_type
        && cfg.left_preamp_gain == 7'h42 |=> mode.left_gain_valid && mode.left_gain_db == 5'h02)
        else $error("left gain code 0x42 not 2 dB");

    a_right_gain_rsv: assert property ((cfg.path_input_type
        || cfg.right_preamp_gain >= 7'h60) |=> !mode.right_gain_valid)
        else $error("right gain used with digital input or reserved code");

    a_left_src_wr: assert property (wr_src_hi |=>
        cfg.left_source_select == $past(writedata[14:13]))
        else $error("left source select not written");

    a_low_power_an: assert property (cfg.path_input_type |=> !mode.left_low_power)
        else $error("low power applied with digital input");

    a_p1r_low_power: assert property (wr_p1r_hi |=>
        cfg.path1_right_low_power_select == $past(writedata[11])
        ##1 mode.path1_right_low_power == $past(cfg.path1_right_low_power_select))
        else $error("path 1 right low power not written");

endmodule : ipc_input_path_regs

//--- rtl/ipc_mic_clock_gen.sv
// phase accumulator that makes the digital mic clock and its edge pulses
`timescale 1ns/1ps
module ipc_mic_clock_gen #(
    parameter int unsigned ACC_W = 24
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // control
    input  wire logic             run,
    input  wire logic [ACC_W-1:0] increment,
    // mic clock and edge pulses
    output logic                  mic_clk,
    output logic                  rise_pulse,
    output logic                  fall_pulse
);

    logic [ACC_W-1:0] acc;      // phase accumulator
    logic [ACC_W:0]   sum;      // accumulator plus carry
    logic             toggle;   // half period elapsed

    assign sum    = {1'b0, acc} + {1'b0, increment};
    assign toggle = run & sum[ACC_W];

    // accumulate while running, park low and cleared when stopped
    always_ff @(posedge clk) begin
        if (!rst_n || !run) begin
            acc        <= '0;
            mic_clk    <= 1'b0;
            rise_pulse <= 1'b0;
            fall_pulse <= 1'b0;
        end else begin
            acc        <= sum[ACC_W-1:0];
            mic_clk    <= mic_clk ^ toggle;
            rise_pulse <= toggle & ~mic_clk;
            fall_pulse <= toggle & mic_clk;
        end
    end

endmodule : ipc_mic_clock_gen

//--- rtl/ipc_pkg.sv
// constants, field layouts and carrier types for the input path configuration registers
package ipc_pkg;

    // bus geometry
    localparam int unsigned ADDR_W  = 12;                 // byte address width
    localparam int unsigned DATA_W  = 32;                 // bus data width
    localparam int unsigned IDX_W   = 10;                 // register index width

    // register indices, byte address is four times the index
    localparam logic [9:0] IDX_P1R_SOURCE   = 10'h315;    // path 1 right source, low-power bit
    localparam logic [9:0] IDX_P2L_CONTROL  = 10'h318;    // path2_left_control
    localparam logic [9:0] IDX_P2L_SOURCE   = 10'h319;    // path2_left_source_select
    localparam logic [9:0] IDX_P2_OVERSAMP  = 10'h31A;    // path2_oversample_control
    localparam logic [9:0] IDX_P2R_CONTROL  = 10'h31C;    // path2_right_control
    localparam logic [9:0] IDX_STATUS       = 10'h3F0;    // read-only block state

    // field positions
    localparam int unsigned HPF_BIT     = 15;             // highpass enable
    localparam int unsigned REF_MSB     = 12;             // mic reference select
    localparam int unsigned REF_LSB     = 11;
    localparam int unsigned TYPE_BIT    = 10;             // path input type
    localparam int unsigned GAIN_MSB    = 7;              // preamp gain
    localparam int unsigned GAIN_LSB    = 1;
    localparam int unsigned SRC_MSB     = 14;             // left source select
    localparam int unsigned SRC_LSB     = 13;
    localparam int unsigned LP_BIT      = 11;             // low-power select
    localparam int unsigned OSR_MSB     = 10;             // oversample rate select
    localparam int unsigned OSR_LSB     = 8;

    // reset values
    localparam logic       RST_HPF  = 1'b0;
    localparam logic [1:0] RST_REF  = 2'h0;
    localparam logic       RST_TYPE = 1'b0;
    localparam logic [6:0] RST_GAIN = 7'h40;
    localparam logic [1:0] RST_SRC  = 2'h0;
    localparam logic       RST_LP   = 1'b0;
    localparam logic [2:0] RST_OSR  = 3'h5;

    // field encodings
    localparam logic [1:0] REF_RESERVED = 2'h3;           // reserved reference code
    localparam logic [6:0] GAIN_ZERO_DB = 7'h40;          // 0 dB, 1 dB steps upward
    localparam logic [6:0] GAIN_FIRST_RSV = 7'h60;        // first reserved code above range
    localparam logic [2:0] OSR_384K  = 3'h2;
    localparam logic [2:0] OSR_768K  = 3'h3;
    localparam logic [2:0] OSR_1536K = 3'h4;              // also mid-power for analog input
    localparam logic [2:0] OSR_3072K = 3'h5;              // also normal for analog input
    localparam logic [2:0] OSR_6144K = 3'h6;

    // avalon response codes
    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // mic clock timing, phase accumulator toggles twice per mic clock period
    localparam longint unsigned CLK_HZ   = 20000000;
    localparam longint unsigned F384K_HZ = 384000;
    localparam longint unsigned F768K_HZ = 768000;
    localparam longint unsigned F1536K_HZ = 1536000;
    localparam longint unsigned F3072K_HZ = 3072000;
    localparam longint unsigned F6144K_HZ = 6144000;
    localparam int unsigned     NCO_W    = 24;
    localparam longint unsigned NCO_ONE  = 64'd1 << NCO_W;
    localparam logic [23:0] INC_384K  = 24'((2 * F384K_HZ  * NCO_ONE) / CLK_HZ);
    localparam logic [23:0] INC_768K  = 24'((2 * F768K_HZ  * NCO_ONE) / CLK_HZ);
    localparam logic [23:0] INC_1536K = 24'((2 * F1536K_HZ * NCO_ONE) / CLK_HZ);
    localparam logic [23:0] INC_3072K = 24'((2 * F3072K_HZ * NCO_ONE) / CLK_HZ);
    localparam logic [23:0] INC_6144K = 24'((2 * F6144K_HZ * NCO_ONE) / CLK_HZ);

    // stored configuration fields
    typedef struct packed {
        logic       left_highpass_enable;
        logic       right_highpass_enable;
        logic [1:0] mic_reference_select;
        logic       path_input_type;
        logic [2:0] oversample_rate_select;
        logic [6:0] left_preamp_gain;
        logic [6:0] right_preamp_gain;
        logic [1:0] left_source_select;
        logic       left_low_power_select;
        logic       path1_right_low_power_select;
    } ipc_cfg_t;

    // effective operating modes derived from the fields
    typedef struct packed {
        logic       digital_active;        // digital microphone input in use
        logic       mid_power_active;      // analog mid-power mode
        logic       left_low_power;        // path 2 left low power, analog only
        logic       path1_right_low_power; // path 1 right low power, for any input type
        logic       left_gain_valid;       // analog input and left gain code in 0 dB..31 dB range
        logic       right_gain_valid;      // analog input and right gain code in 0 dB..31 dB range
        logic [4:0] left_gain_db;          // left preamp gain in dB
        logic [4:0] right_gain_db;         // right preamp gain in dB
    } ipc_mode_t;

endpackage : ipc_pkg

//--- verif/ipc_input_path_regs_tb_top.sv
// self-checking bench for the input path configuration registers
`timescale 1ns/1ps
module ipc_input_path_regs_tb_top;
    typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e;} ipc_row_t;
    logic clk = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0, mic_data_input;
    logic [11:0] address = 12'h000;
    logic [31:0] writedata = 32'h0, readdata, rd;
    logic [3:0]  byteenable = 4'hF;
    logic [1:0]  response, rsp;
    logic waitrequest, mic_clock_output, lb, ls, rb, rs, bad;
    ipc_pkg::ipc_cfg_t  cfg;
    ipc_pkg::ipc_mode_t mode;
    int error_cnt = 0, checks = 0, n;
    // reset reads first, then write and read back
    ipc_row_t rows [10] = '{
        '{1'b0, 12'hC60, 32'h0, 32'h0080}, '{1'b0, 12'hC64, 32'h0, 32'h0000},
        '{1'b0, 12'hC68, 32'h0, 32'h0500}, '{1'b0, 12'hC70, 32'h0, 32'h0080},
        '{1'b0, 12'hC54, 32'h0, 32'h0000}, '{1'b1, 12'hC60, 32'h9084, 32'h9084},
        '{1'b1, 12'hC64, 32'h6800, 32'h6800}, '{1'b1, 12'hC68, 32'h0400, 32'h0400},
        '{1'b1, 12'hC70, 32'h80BE, 32'h80BE}, '{1'b1, 12'hC54, 32'h0800, 32'h0800}};
    ipc_input_path_regs u_ipc_input_path_regs (.clk(clk), .rst_n(rst_n), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
        .waitrequest(waitrequest), .readdata(readdata), .response(response), .cfg(cfg),
        .mode(mode), .mic_clock_output(mic_clock_output), .mic_data_input(mic_data_input),
        .mic_left_bit(lb), .mic_left_strobe(ls), .mic_right_bit(rb), .mic_right_strobe(rs));
    ipc_mic_model u_ipc_mic_model (.clk(clk), .mic_clock_output(mic_clock_output),
        .mic_data_input(mic_data_input));
    initial begin
        forever #25 clk = ~clk;
    end
    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        int k;
        k = 0;
        address <= a; writedata <= d; byteenable <= be; write <= w; read <= ~w;
        do @(posedge clk); while (waitrequest !== 1'b0 && ++k < 50);
        if (k >= 50) error_cnt++;
        rd = readdata;
        rsp = response;
        write <= 1'b0; read <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (rows[i]) begin
            if (rows[i].w) bus(1'b1, rows[i].a, rows[i].d, 4'hF);
            bus(1'b0, rows[i].a, 32'h0, 4'hF);
            chk(rd, rows[i].e);
        end
        chk({mode.left_gain_db, mode.right_gain_db}, {5'h02, 5'h1F});
        chk({mode.left_low_power, mode.path1_right_low_power}, 2'h3);
        bus(1'b0, 12'hC6C, 32'h0, 4'hF);
        chk(rd, 32'h0);
        chk({30'h0, rsp}, {30'h0, ipc_pkg::RESP_SLVERR});
        // lane 0 only: gain takes 0x5F, upper fields keep their values
        bus(1'b1, 12'hC60, 32'hFFBE, 4'h1);
        bus(1'b0, 12'hC60, 32'h0, 4'hF);
        chk(rd, 32'h90BE);
        chk({mode.left_gain_valid, mode.left_gain_db}, {1'b1, 5'h1F});
        bus(1'b1, 12'hC60, 32'h0400, 4'h2);
        bus(1'b1, 12'hC68, 32'h0500, 4'hF);
        n = 0; bad = 1'b0;
        repeat (2000) begin
            @(posedge clk);
            if (ls === 1'b1) n++;
            if ((ls === 1'b1 && lb !== 1'b1) || (rs === 1'b1 && rb !== 1'b0)) bad = 1'b1;
        end
        chk(n >= 306 && n <= 308, 1'b1);
        chk(bad, 1'b0);
        chk({mode.left_low_power, mode.left_gain_valid, mode.right_gain_valid,
             mode.digital_active}, 4'h1);
        bus(1'b1, 12'hC60, 32'h0000, 4'h2);
        bus(1'b1, 12'hC68, 32'h0400, 4'hF);
        repeat (4) @(posedge clk);
        chk({mic_clock_output, mode.mid_power_active, mode.digital_active}, 3'h2);
        bus(1'b0, 12'hFC0, 32'h0, 4'hF);
        chk(rd, 32'h0);
        // mid-run reset must bring back the reset values
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        bus(1'b0, 12'hC60, 32'h0, 4'hF);
        chk(rd, 32'h0080);
        bus(1'b0, 12'hC70, 32'h0, 4'hF);
        chk(rd, 32'h0080);
        give_verdict();
    end
    // hang guard well beyond the expected run
    initial begin
        #2000000;
        error_cnt++;
        give_verdict();
    end
endmodule : ipc_input_path_regs_tb_top

//--- verif/ipc_mic_model.sv
// digital microphone model feeding the mic data pin
`timescale 1ns/1ps
module ipc_mic_model (
    // clocking
    input  wire logic clk,
    input  wire logic mic_clock_output,
    // data pin
    output logic      mic_data_input
);
    logic last_clk;     // mic clock seen one cycle ago
    int   idle;         // cycles without a mic clock edge
    initial begin
        mic_data_input = 1'b0;
        last_clk = 1'b0;
        idle = 0;
    end
    // once the mic clock has stood still for more than 4 cycles the pin flips every cycle
    always @(posedge clk) begin
        idle <= (mic_clock_output !== last_clk) ? 0 : idle + 1;
        last_clk <= mic_clock_output;
        if (idle > 4) mic_data_input <= ~mic_data_input;
    end
    // left word after a rising mic clock, right word after a falling one
    always @(posedge mic_clock_output) mic_data_input <= 1'b1;
    always @(negedge mic_clock_output) mic_data_input <= 1'b0;
endmodule : ipc_mic_model
